// File: common/dma_seq_pkg.sv
/*
  Constants, register map and state type used by the four-channel DMA
  transfer sequencer; its priority arbiter takes none of them.
  Assumes an 8-bit register port with a 4-bit register index.
*/
// Summary of operation
// RL1: Enabled channel request raises hold_request.
// RL2: Wait hold_acknowledge, then drive channel acknowledge low.
// RL3: Acknowledge low frames read/write strobes for byte.
// RL4: After transfer: acknowledge high, hold_request low.
// RL5: Peripheral drops request before fourth transfer state.
// RL6: Sample requests each fourth state, no switch cost.
// RL7: Higher request pre-empts lower burst, lower resumes.
// RL8: hold_request stays high while any request remains.
// RL9: Hold acknowledge withdrawn: finish, drop hold, idle.
// RL10: Requests still active: reassert hold third cycle.
// RL11: Ready low in state three inserts waits.
// RL12: Four clocks per byte without wait states.
// RL13: Count top bits: verify, write, read types.
// RL14: Software loads count as bytes minus one.
// RL15: Memory-mapped wiring swaps read and write bits.
// RL16: Memory-mapped system crosses control line wiring.
// RL17: Count-end flag sticky until status read.
// RL18: Byte toggle flips per access, cleared by mode.
// RL19: Reset leaves hold low, acknowledges high, idle.
package dma_seq_pkg;

  localparam int NUM_CH = 4;
  localparam int DATA_W = 8;
  localparam int REG_AW = 4;

  // Register index map: channel n address at 2n, count at 2n+1
  localparam logic [3:0] OFF_MODE = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_MASK = 4'h9;

  // Mode register fields
  localparam int MODE_EN_LSB = 0;
  localparam int MODE_ROT_EN = 4;
  localparam int MODE_EARLY_WR = 5;
  localparam int MODE_STOP_END = 6;
  localparam int MODE_AUTO_LOAD = 7;

  // Status register fields
  localparam int STAT_END_LSB = 0;
  localparam int STAT_UP = 4;

  // Count register fields
  localparam int CNT_W = 14;
  localparam int CNT_WR_BIT = 14;
  localparam int CNT_RD_BIT = 15;

  // Cycle type, written as {read bit, write bit}
  localparam logic [1:0] CYC_VERIFY = 2'h0;
  localparam logic [1:0] CYC_WRITE = 2'h1;
  localparam logic [1:0] CYC_READ = 2'h2;

  // Auto load copies the spare channel into the reloaded one
  localparam logic [1:0] RELOAD_CH = 2'h2;
  localparam logic [1:0] SPARE_CH = 2'h3;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [15:0] CH_ADDR_RST = 16'h0000;
  localparam logic [15:0] CH_CNT_RST = 16'h0000;

  // Idle cycles after an override before hold is raised again
  localparam logic [1:0] OVR_GAP_CYC = 2'h2;

  typedef enum logic [2:0] {
    st_idle,
    st_t0,
    st_t1,
    st_t2,
    st_t3,
    st_wait,
    st_fourth_transfer_state,
    st_ovr
  } state_t;

endpackage : dma_seq_pkg

// File: common/arb_if.sv
/*
  Carrier between the sequencer and its channel priority arbiter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface arb_if;
  logic [3:0] req;
  logic rot_en;
  logic advance;
  logic valid;
  logic [1:0] ch;

  modport arb (input req, input rot_en, input advance,
               output valid, output ch);
  modport user (output req, output rot_en, output advance,
                input valid, input ch);
endinterface : arb_if

// File: logic/dma_priority_arbiter.sv
/*
  Channel priority arbiter: fixed order with channel 0 highest, or
  rotating order where the last served channel drops to lowest.
  Assumes requests are already qualified by the channel enables.
*/
`timescale 1ns/1ps
module dma_priority_arbiter (
  input wire logic ref_clk,
  input wire logic rst,
  arb_if.arb bus
);

  logic [1:0] last_r;
  logic [1:0] base;

  assign base = bus.rot_en ? 2'(last_r + 2'h1) : 2'h0;

  // Lowest offset from the base wins, so the loop runs downward
  always_comb begin
    logic [1:0] idx;
    idx = 2'h0;
    bus.valid = 1'b0;
    bus.ch = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      idx = 2'(base + 2'(i));
      if (bus.req[idx]) begin
        bus.valid = 1'b1;
        bus.ch = idx;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_r <= 2'h3;
    end else if (bus.advance) begin
      last_r <= bus.ch;
    end
  end

endmodule : dma_priority_arbiter

// File: logic/dma_transfer_sequencer.sv
/*
  Four-channel byte DMA transfer sequencer: channel registers, mode,
  status and mask registers, bus hold handshake, transfer state machine,
  strobe generation and count-end interrupt.
  Assumes all inputs are synchronous to ref_clk and that software does
  not reprogram a channel while it is being served.
*/
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module dma_transfer_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] dma_request,
  output logic [3:0] dma_acknowledge_n,
  output logic hold_request,
  input wire logic hold_acknowledge,
  input wire logic ready,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic io_rd_n,
  output logic io_wr_n,
  output logic [15:0] dma_addr,
  output logic addr_valid,
  output logic count_end,
  output logic irq
);

  localparam int NCH = dma_seq_pkg::NUM_CH;

  logic [15:0] ch_addr_r [NCH];
  logic [15:0] ch_cnt_r [NCH];
  logic [7:0] mode_r;
  logic [3:0] mask_r;
  logic [3:0] end_flags_r;
  logic up_r;
  logic byte_hi_r;
  logic hold_r;
  logic hold_nxt;
  logic [1:0] cur_ch_r;
  logic [1:0] cur_ch_nxt;
  logic [1:0] ovr_cnt_r;
  logic [1:0] ovr_cnt_nxt;
  logic [7:0] rdata_r;
  dma_seq_pkg::state_t state_r;
  dma_seq_pkg::state_t state_nxt;

  // Decode and selection nets
  logic ch_acc;
  logic [1:0] ch_idx;
  logic cnt_sel;
  logic mode_wr;
  logic mask_wr;
  logic stat_rd;
  logic ch_touch;
  logic [3:0] chan_en;
  logic [15:0] cur_cnt;
  logic [1:0] cyc_type;
  logic in_fourth;
  logic end_hit;
  logic [3:0] end_onehot;
  logic [3:0] stop_mask;
  logic reload;
  logic [3:0] req_live;
  logic any_req;
  logic grant_take;
  logic ack_phase;
  logic rd_phase;
  logic wr_phase;
  logic is_write;
  logic is_read;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  logic [7:0] status_val;
  logic [7:0] rd_mux;

  arb_if arb ();

  dma_priority_arbiter u_arb (
    .ref_clk(ref_clk),
    .rst(rst),
    .bus(arb.arb)
  );

  // Register port decode
  assign ch_acc = (reg_addr[3] == 1'b0);
  assign ch_idx = reg_addr[2:1];
  assign cnt_sel = reg_addr[0];
  assign mode_wr = reg_wr && (reg_addr == dma_seq_pkg::OFF_MODE);
  assign mask_wr = reg_wr && (reg_addr == dma_seq_pkg::OFF_MASK);
  assign stat_rd = reg_rd && (reg_addr == dma_seq_pkg::OFF_STATUS);
  assign ch_touch = (reg_wr || reg_rd) && ch_acc;

  // Transfer decode
  assign chan_en = mode_r[dma_seq_pkg::MODE_EN_LSB +: 4];
  assign cur_cnt = ch_cnt_r[cur_ch_r];
  assign cyc_type =
    {cur_cnt[dma_seq_pkg::CNT_RD_BIT], cur_cnt[dma_seq_pkg::CNT_WR_BIT]};
  assign in_fourth = (state_r == dma_seq_pkg::st_fourth_transfer_state);
  // Zero in the count field marks the last byte of the block [RL14]
  assign end_hit =
    in_fourth && (cur_cnt[dma_seq_pkg::CNT_W-1:0] == 14'h0000); // [RL17]
  assign end_onehot = end_hit ? 4'(4'h1 << cur_ch_r) : 4'h0;
  assign stop_mask = mode_r[dma_seq_pkg::MODE_STOP_END] ? end_onehot : 4'h0;
  assign reload = end_hit && mode_r[dma_seq_pkg::MODE_AUTO_LOAD] &&
                  (cur_ch_r == dma_seq_pkg::RELOAD_CH);
  // A channel that just stopped on count end must not be granted again
  assign req_live = dma_request & chan_en & ~stop_mask; // [RL1]
  assign any_req = |req_live;
  assign grant_take =
    hold_acknowledge && arb.valid &&
    ((state_r == dma_seq_pkg::st_t0) || in_fourth);

  assign arb.req = req_live;
  assign arb.rot_en = mode_r[dma_seq_pkg::MODE_ROT_EN];
  assign arb.advance = grant_take;

  // Strobe phases; early write opens the write strobe one state sooner
  assign ack_phase =
    (state_r == dma_seq_pkg::st_t1) || (state_r == dma_seq_pkg::st_t2) ||
    (state_r == dma_seq_pkg::st_t3) || (state_r == dma_seq_pkg::st_wait) ||
    in_fourth;
  assign rd_phase =
    (state_r == dma_seq_pkg::st_t2) || (state_r == dma_seq_pkg::st_t3) ||
    (state_r == dma_seq_pkg::st_wait);
  assign wr_phase =
    (state_r == dma_seq_pkg::st_t3) || (state_r == dma_seq_pkg::st_wait) ||
    ((state_r == dma_seq_pkg::st_t2) && mode_r[dma_seq_pkg::MODE_EARLY_WR]);
  // Memory-mapped systems program the bits swapped; wiring does the rest
  assign is_write = (cyc_type == dma_seq_pkg::CYC_WRITE); // [RL13] [RL15]
  assign is_read = (cyc_type == dma_seq_pkg::CYC_READ); // [RL13]

  // Write cycle moves peripheral to memory, read cycle memory to peripheral
  assign io_rd_n = ~(rd_phase && is_write); // [RL3] [RL16]
  assign mem_wr_n = ~(wr_phase && is_write); // [RL3]
  assign mem_rd_n = ~(rd_phase && is_read); // [RL3]
  assign io_wr_n = ~(wr_phase && is_read); // [RL3]
  // Verify and the illegal code run the states with no strobe at all

  // Acknowledge is the peripheral's chip select for the whole transfer
  assign dma_acknowledge_n =
    ack_phase ? ~(4'(4'h1 << cur_ch_r)) : 4'hf; // [RL2] [RL3] [RL4]
  assign addr_valid = ack_phase;
  assign dma_addr = ch_addr_r[cur_ch_r];
  assign count_end = end_hit;
  assign hold_request = hold_r;
  assign reg_rdata = rdata_r;
  assign irq = |(end_flags_r & mask_r);

  // Transfer state machine
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    cur_ch_nxt = cur_ch_r;
    ovr_cnt_nxt = ovr_cnt_r;
    unique case (state_r)
      dma_seq_pkg::st_idle: begin
        if (any_req) begin
          hold_nxt = 1'b1; // [RL1]
          state_nxt = dma_seq_pkg::st_t0;
        end
      end
      dma_seq_pkg::st_t0: begin
        if (!any_req) begin
          hold_nxt = 1'b0;
          state_nxt = dma_seq_pkg::st_idle;
        end else if (hold_acknowledge) begin
          cur_ch_nxt = arb.ch; // [RL2]
          state_nxt = dma_seq_pkg::st_t1;
        end
      end
      dma_seq_pkg::st_t1: begin
        state_nxt = dma_seq_pkg::st_t2; // [RL12]
      end
      dma_seq_pkg::st_t2: begin
        state_nxt = dma_seq_pkg::st_t3; // [RL12]
      end
      dma_seq_pkg::st_t3: begin
        if (ready) begin
          state_nxt = dma_seq_pkg::st_fourth_transfer_state; // [RL11]
        end else begin
          state_nxt = dma_seq_pkg::st_wait; // [RL11]
        end
      end
      dma_seq_pkg::st_wait: begin
        if (ready) begin
          state_nxt = dma_seq_pkg::st_fourth_transfer_state; // [RL11]
        end
      end
      dma_seq_pkg::st_fourth_transfer_state: begin
        // Requests still high here cause another transfer [RL5]
        if (!hold_acknowledge) begin
          hold_nxt = 1'b0; // [RL9]
          ovr_cnt_nxt = 2'h0;
          state_nxt = dma_seq_pkg::st_ovr; // [RL9]
        end else if (arb.valid) begin
          // Straight into the next transfer, no idle state [RL6] [RL7]
          cur_ch_nxt = arb.ch; // [RL6] [RL7]
          state_nxt = dma_seq_pkg::st_t1; // [RL8] [RL12]
        end else begin
          hold_nxt = 1'b0; // [RL4] [RL8]
          state_nxt = dma_seq_pkg::st_idle; // [RL4]
        end
      end
      dma_seq_pkg::st_ovr: begin
        if (ovr_cnt_r == 2'(dma_seq_pkg::OVR_GAP_CYC - 2'h1)) begin
          if (any_req) begin
            hold_nxt = 1'b1; // [RL10]
            state_nxt = dma_seq_pkg::st_t0; // [RL10]
          end else begin
            state_nxt = dma_seq_pkg::st_idle;
          end
        end else begin
          ovr_cnt_nxt = 2'(ovr_cnt_r + 2'h1);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= dma_seq_pkg::st_idle; // [RL19]
      hold_r <= 1'b0; // [RL19]
      cur_ch_r <= 2'h0;
      ovr_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      cur_ch_r <= cur_ch_nxt;
      ovr_cnt_r <= ovr_cnt_nxt;
    end
  end

  // Channel address and count registers
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire logic wr_this = reg_wr && ch_acc && (ch_idx == 2'(c));
    wire logic run_this = in_fourth && (cur_ch_r == 2'(c));
    wire logic reload_this = reload && (2'(c) == dma_seq_pkg::RELOAD_CH);

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        ch_addr_r[c] <= dma_seq_pkg::CH_ADDR_RST;
        ch_cnt_r[c] <= dma_seq_pkg::CH_CNT_RST;
      end else if (wr_this) begin
        // Software writes win; reprogramming a live channel is unsafe
        if (cnt_sel && byte_hi_r) begin
          ch_cnt_r[c][15:8] <= reg_wdata; // [RL18]
        end else if (cnt_sel) begin
          ch_cnt_r[c][7:0] <= reg_wdata; // [RL18]
        end else if (byte_hi_r) begin
          ch_addr_r[c][15:8] <= reg_wdata; // [RL18]
        end else begin
          ch_addr_r[c][7:0] <= reg_wdata; // [RL18]
        end
      end else if (reload_this) begin
        ch_addr_r[c] <= ch_addr_r[dma_seq_pkg::SPARE_CH];
        ch_cnt_r[c] <= ch_cnt_r[dma_seq_pkg::SPARE_CH];
      end else if (run_this) begin
        ch_addr_r[c] <= 16'(ch_addr_r[c] + 16'h0001);
        ch_cnt_r[c][dma_seq_pkg::CNT_W-1:0] <=
          14'(ch_cnt_r[c][dma_seq_pkg::CNT_W-1:0] - 14'h0001);
      end
    end
  end

  // Mode register and count-end stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= dma_seq_pkg::MODE_RST;
    end else if (mode_wr) begin
      // Software beats a count-end stop falling in the same cycle
      mode_r <= reg_wdata;
    end else begin
      // Count-end stop clears the enable bit of the finished channel
      mode_r[dma_seq_pkg::MODE_EN_LSB +: 4] <= chan_en & ~stop_mask;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= dma_seq_pkg::MASK_RST;
    end else if (mask_wr) begin
      mask_r <= reg_wdata[3:0];
    end
  end

  // Flags clear only on a status read, never on a register write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      end_flags_r <= 4'h0; // [RL17]
    end else begin
      // A count end in the read cycle survives the clear [RL17]
      end_flags_r <= (stat_rd ? 4'h0 : end_flags_r) | end_onehot; // [RL17]
    end
  end

  // Update flag: set by auto load, cleared when the reloaded block runs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_r <= 1'b0;
    end else if (reload) begin
      up_r <= 1'b1;
    end else if (mode_wr && !reg_wdata[dma_seq_pkg::MODE_AUTO_LOAD]) begin
      up_r <= 1'b0;
    end else if (in_fourth && (cur_ch_r == dma_seq_pkg::RELOAD_CH)) begin
      up_r <= 1'b0;
    end
  end

  // Pairs of byte accesses must not be split or the toggle desyncs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_hi_r <= 1'b0; // [RL18]
    end else if (mode_wr) begin
      byte_hi_r <= 1'b0; // [RL18]
    end else if (ch_touch) begin
      byte_hi_r <= ~byte_hi_r; // [RL18]
    end
  end

  // Read data, valid only in the cycle after the read strobe
  assign rd_word = cnt_sel ? ch_cnt_r[ch_idx] : ch_addr_r[ch_idx];
  assign rd_byte = byte_hi_r ? rd_word[15:8] : rd_word[7:0];
  assign status_val = {3'h0, up_r, end_flags_r};
  assign rd_mux =
    ch_acc ? rd_byte :
    (reg_addr == dma_seq_pkg::OFF_STATUS) ? status_val :
    (reg_addr == dma_seq_pkg::OFF_MASK) ? {4'h0, mask_r} : 8'h00;

  // Idle read data is zero so a stale byte never looks like an answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule : dma_transfer_sequencer

// File: bench/host_model.sv
/*
  Host side of the bus hold handshake: grants the bus and drives ready.
  Assumes the bench steers slow between transfers and raises override mid-burst.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hold_request,
  input wire logic addr_valid,
  input wire logic override,
  input wire logic slow,
  output logic hold_acknowledge,
  output logic ready
);
  logic [2:0] wcnt_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_acknowledge <= 1'b0;
      wcnt_r <= 3'h0;
    end else begin
      // Grant one cycle late; override withdraws it mid-burst
      hold_acknowledge <= hold_request && !override;
      wcnt_r <= addr_valid ? wcnt_r + 3'h1 : 3'h0;
    end
  end
  // Slow mode holds ready low for two cycles from state three
  assign ready = !slow || (wcnt_r >= 3'h4);
endmodule : host_model

// File: bench/dma_seq_monitor.sv
/*
  Port checker for the transfer sequencer.
  Assumes it is bound onto the sequencer's top module.
*/
`timescale 1ns/1ps
module dma_seq_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] dma_request,
  input wire logic [3:0] dma_acknowledge_n,
  input wire logic hold_request,
  input wire logic hold_acknowledge,
  input wire logic ready,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic addr_valid,
  input wire logic count_end,
  input wire logic irq
);
  wire ack_any = ~&dma_acknowledge_n;
  wire wr_low = ~(mem_wr_n & io_wr_n);
  wire strb_any = ~(mem_rd_n & mem_wr_n & io_rd_n & io_wr_n);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property ($fell(rst) |->
    !hold_request && dma_acknowledge_n == 4'hf && !irq)
    else $error("not idle after reset");
  a_hold_cause: assert property ($rose(hold_request) |->
    $past(|dma_request)) else $error("hold raised without request");
  a_grant_first: assert property ($rose(ack_any) |->
    $past(hold_acknowledge) && hold_request)
    else $error("acknowledge before grant");
  a_one_lane: assert property ($onehot0(~dma_acknowledge_n))
    else $error("two acknowledge lanes low");
  a_strobe_framed: assert property (strb_any |->
    ack_any && addr_valid) else $error("strobe outside acknowledge");
  a_hold_covers: assert property (ack_any |-> hold_request)
    else $error("acknowledge without hold");
  a_bus_release: assert property ($fell(hold_request) |-> !ack_any)
    else $error("hold dropped with acknowledge low");
  a_write_slot: assert property ($rose(ack_any) ##1 !io_rd_n
    ##1 (ready && !mem_wr_n) |=> mem_wr_n && ack_any)
    else $error("write strobe outside third cycle");
  a_wait_holds: assert property ((wr_low && !ready) |=> wr_low)
    else $error("wait state lost write strobe");
  a_end_slot: assert property (count_end |-> ack_any && !strb_any)
    else $error("count end outside fourth state");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  c_transfer: cover property ($rose(ack_any));
  c_wait: cover property (!ready && ack_any);
  c_count_end: cover property (count_end);
  c_regrant: cover property ($fell(hold_request) ##2 hold_request);
endmodule : dma_seq_monitor

// File: bench/tb.sv
/*
  Sequence tests for the transfer sequencer over its register port.
  Assumes the host model answers the hold handshake.
*/
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic override = 1'b0;
  logic slow = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [3:0] dma_request = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] dma_acknowledge_n;
  logic hold_request, hold_acknowledge, ready, addr_valid, count_end, irq;
  logic mem_rd_n, mem_wr_n, io_rd_n, io_wr_n;
  logic [15:0] dma_addr;
  logic [7:0] ctype [3] = '{8'h40, 8'h80, 8'h00};
  // Code 01 is a write cycle, strobing mem_wr_n and io_rd_n
  logic [3:0] strb [3] = '{4'h6, 4'h9, 4'h0};
  int bad_count = 0;
  int n_tests = 0;
  int n;
  always #50 ref_clk = ~ref_clk;
  dma_transfer_sequencer uut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_request(dma_request),
    .dma_acknowledge_n(dma_acknowledge_n), .hold_request(hold_request),
    .hold_acknowledge(hold_acknowledge), .ready(ready),
    .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .dma_addr(dma_addr), .addr_valid(addr_valid),
    .count_end(count_end), .irq(irq));
  host_model host (.ref_clk(ref_clk), .rst(rst),
    .hold_request(hold_request), .addr_valid(addr_valid),
    .override(override), .slow(slow),
    .hold_acknowledge(hold_acknowledge), .ready(ready));
  task report_and_stop;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task step;
    @(posedge ref_clk);
    #1;
  endtask : step
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", 16'(exp), 16'(reg_rdata));
  endtask : rd
  // One transfer on lane ack; drop and set change requests at its start
  task serve(input logic [3:0] ack, input logic [15:0] addr, input int len,
             input logic [3:0] s, input logic [3:0] drop,
             input logic [3:0] set);
    logic [3:0] seen;
    seen = 4'h0;
    n = 0;
    while (dma_acknowledge_n === 4'hf && n < 40) begin
      n++;
      step();
    end
    chk("lane", 16'(ack), 16'(dma_acknowledge_n));
    chk("addr", addr, dma_addr);
    chk("valid", 16'h1, 16'(addr_valid));
    dma_request <= (dma_request & ~drop) | set;
    n = 0;
    while (dma_acknowledge_n === ack && n < 40) begin
      seen = seen | ~{mem_rd_n, mem_wr_n, io_rd_n, io_wr_n};
      n++;
      step();
    end
    chk("cycles", 16'(len), 16'(n));
    chk("strobes", 16'(s), 16'(seen));
  endtask : serve
  initial begin
    #2000000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    step();
    chk("hold", 16'h0, 16'(hold_request));
    chk("ack", 16'hf, 16'(dma_acknowledge_n));
    rd(4'h8, 8'h00);
    rd(4'hc, 8'h00);
    dma_request <= 4'h2;
    repeat (5) step();
    chk("hold", 16'h0, 16'(hold_request));
    dma_request <= 4'h0;
    wr(4'h9, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr(4'h8, 8'h02);
      wr(4'h2, 8'h34);
      wr(4'h2, 8'h12);
      wr(4'h3, 8'h00);
      wr(4'h3, ctype[i]);
      slow <= (i == 1);
      dma_request <= 4'h2;
      serve(4'hd, 16'h1234, (i == 1) ? 6 : 4, strb[i], 4'h2, 4'h0);
      chk("hold", 16'h0, 16'(hold_request));
      chk("irq", 16'h1, 16'(irq));
      rd(4'h8, 8'h02);
      #1;
      chk("irq", 16'h0, 16'(irq));
    end
    slow <= 1'b0;
    wr(4'h8, 8'h05);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h40);
    wr(4'h5, 8'h01);
    wr(4'h5, 8'h40);
    dma_request <= 4'h4;
    serve(4'hb, 16'h0000, 4, 4'h6, 4'h0, 4'h1);
    chk("hold", 16'h1, 16'(hold_request));
    serve(4'he, 16'h0000, 4, 4'h6, 4'h1, 4'h0);
    serve(4'hb, 16'h0001, 4, 4'h6, 4'h4, 4'h0);
    chk("hold", 16'h0, 16'(hold_request));
    chk("irq", 16'h0, 16'(irq));
    rd(4'h8, 8'h05);
    wr(4'h8, 8'h08);
    wr(4'h7, 8'h03);
    wr(4'h7, 8'h40);
    dma_request <= 4'h8;
    n = 0;
    while (dma_acknowledge_n !== 4'h7 && n < 40) begin
      n++;
      step();
    end
    override <= 1'b1;
    n = 0;
    while (hold_request !== 1'b0 && n < 40) begin
      n++;
      step();
    end
    chk("hold", 16'h0, 16'(hold_request));
    chk("ack", 16'hf, 16'(dma_acknowledge_n));
    override <= 1'b0;
    n = 0;
    while (hold_request !== 1'b1 && n < 40) begin
      n++;
      step();
    end
    chk("gap", 16'h2, 16'(n));
    serve(4'h7, 16'h0001, 4, 4'h6, 4'h8, 4'h0);
    chk("hold", 16'h0, 16'(hold_request));
    // Stop on count end: a request left high must not restart ch1
    wr(4'h8, 8'h42);
    wr(4'h3, 8'h00);
    wr(4'h3, 8'h40);
    dma_request <= 4'h2;
    serve(4'hd, 16'h1235, 4, 4'h6, 4'h0, 4'h0);
    repeat (3) step();
    chk("hold", 16'h0, 16'(hold_request));
    dma_request <= 4'h0;
    rd(4'h8, 8'h02);
    report_and_stop();
  end
endmodule : tb
bind dma_transfer_sequencer dma_seq_monitor mon (.ref_clk(ref_clk),
  .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .dma_request(dma_request), .dma_acknowledge_n(dma_acknowledge_n),
  .hold_request(hold_request), .hold_acknowledge(hold_acknowledge),
  .ready(ready), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
  .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .addr_valid(addr_valid),
  .count_end(count_end), .irq(irq));
